/* src/sadc_top.sv */
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module sadc_top
   import sadc_pkg::*;
(
   input  wire logic          clk_i,               // 125 MHz clock
   input  wire logic          srst_i,              // Sync reset, high
   input  wire logic          standby_i,           // Stop/slow/sleep entered, level
   input  wire logic [AW-1:0] avs_address_i,       // Byte address
   input  wire logic          avs_read_i,          // Read request
   input  wire logic          avs_write_i,         // Write request
   input  wire logic [3:0]    avs_byteenable_i,    // Byte enables
   input  wire logic [31:0]   avs_writedata_i,     // Write data
   output logic [31:0]        avs_readdata_o,      // Read data
   output logic               avs_waitrequest_o,   // Wait request
   input  wire logic          comp_i,              // Comparator output
   output logic [2:0]         chan_sel_o,          // Mux channel
   output logic               chan_valid_o,        // Channel code not reserved
   output logic               analog_input_en_o,   // Analog input path on
   output logic               ladder_connect_o,    // Resistor ladder connected
   output logic               sample_o,            // Sample-hold tracking
   output logic [9:0]         dac_code_o,          // DAC trial code
   output logic               conv_done_irq_o      // Completion pulse
);
   sadc_conv_if conv ();

   logic       ack;
   logic       req;
   logic       acc;
   logic       wr_ctrl1;
   logic       wr_ctrl2;
   logic       rd_high;
   logic [31:0] rd_data;
   logic [31:0] next_rd_data;
   logic       conv_start_bit;
   sadc_mode_t operating_mode_field;
   logic       analog_input_disable;
   logic [3:0] channel_select;
   logic       ladder_always_on;
   logic [2:0] conv_time_code;
   logic       spare_bit4;
   logic       spare_bit0;
   logic [9:0] result;
   logic       conv_done_flag;
   logic       conv_busy_flag;
   logic       mode_ok;
   logic       repeat_pend;
   logic       launch;
   logic       store;
   logic [7:0] ctrl1_val;
   logic [7:0] ctrl2_val;

   sadc_sar u_sar (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .comp_i (comp_i),
      .conv   (conv.sar)
   );

   // Two-cycle slave: request cycle, then answer cycle with waitrequest low
   assign req = avs_read_i | avs_write_i;
   assign acc = req & ack;
   assign avs_waitrequest_o = req & ~ack;
   assign avs_readdata_o = rd_data;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // Writes blocked in standby and on byte lanes other than lane 0
   assign wr_ctrl1 = acc & avs_write_i & avs_byteenable_i[0] & ~standby_i
                     & (avs_address_i == ADDR_CTRL1);
   assign wr_ctrl2 = acc & avs_write_i & avs_byteenable_i[0] & ~standby_i
                     & (avs_address_i == ADDR_CTRL2);
   assign rd_high  = acc & avs_read_i & (avs_address_i == ADDR_RES_HIGH);

   assign ctrl1_val = {conv_start_bit, operating_mode_field, analog_input_disable,
                       channel_select};
   assign ctrl2_val = {2'b00, ladder_always_on, spare_bit4, conv_time_code, spare_bit0};

   always_comb begin
      next_rd_data = 32'h0000_0000;
      if (avs_address_i == ADDR_RES_LOW) begin
         // Live trial bits stand in the low nibble, so they are not stable
         next_rd_data[7:0] = {result[1:0], conv_done_flag, conv_busy_flag,
                              conv.dac_code[3:0]};
      end else if (avs_address_i == ADDR_RES_HIGH) begin
         next_rd_data[7:0] = result[9:2];
      end else if (avs_address_i == ADDR_CTRL1) begin
         next_rd_data[7:0] = ctrl1_val;
      end else if (avs_address_i == ADDR_CTRL2) begin
         next_rd_data[7:0] = ctrl2_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rd_data <= 32'h0000_0000;
      end else if (avs_read_i && !ack) begin
         rd_data <= next_rd_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || standby_i) begin
         operating_mode_field <= sadc_mode_t'(CTRL1_RESET[C1_MODE_LO +: 2]);
         analog_input_disable <= CTRL1_RESET[C1_AIN_DIS];
         channel_select       <= CTRL1_RESET[3:0];
      end else if (wr_ctrl1) begin
         operating_mode_field <= sadc_mode_t'(avs_writedata_i[C1_MODE_LO +: 2]);
         analog_input_disable <= avs_writedata_i[C1_AIN_DIS];
         channel_select       <= avs_writedata_i[3:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || standby_i) begin
         conv_start_bit <= CTRL1_RESET[C1_START];
      end else if (wr_ctrl1 && avs_writedata_i[C1_START]) begin
         conv_start_bit <= 1'b1;
      end else begin
         conv_start_bit <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || standby_i) begin
         ladder_always_on <= CTRL2_RESET[C2_LADDER];
         spare_bit4       <= CTRL2_RESET[4];
         conv_time_code   <= CTRL2_RESET[C2_TIME_LO +: 3];
         spare_bit0       <= CTRL2_RESET[0];
      end else if (wr_ctrl2) begin
         ladder_always_on <= avs_writedata_i[C2_LADDER];
         spare_bit4       <= avs_writedata_i[4];
         conv_time_code   <= avs_writedata_i[C2_TIME_LO +: 3];
         spare_bit0       <= avs_writedata_i[0];
      end
   end

   // Reserved mode falls in with disabled
   assign mode_ok = (operating_mode_field == MODE_SINGLE)
                    || (operating_mode_field == MODE_REPEAT);
   assign conv_busy_flag = conv.busy;
   assign launch = ~conv.busy & ~standby_i & mode_ok
                   & (conv_start_bit | repeat_pend);
   assign conv.start  = launch;
   // Mode 00 or standby kills a running conversion in the same cycle
   assign conv.abort  = standby_i | ~mode_ok;
   assign conv.period = sadc_period(conv_time_code);
   assign store = conv.done & ~standby_i;

   always_ff @(posedge clk_i) begin
      if (srst_i || standby_i) begin
         repeat_pend <= 1'b0;
      end else begin
         repeat_pend <= conv.done & (operating_mode_field == MODE_REPEAT);
      end
   end

   // Standby wipes earlier results as well
   always_ff @(posedge clk_i) begin
      if (srst_i || standby_i) begin
         result <= RESULT_RESET;
      end else if (store) begin
         result <= conv.result;
      end
   end

   // A completion in the cycle of a clearing read still leaves the flag set
   always_ff @(posedge clk_i) begin
      if (srst_i || standby_i) begin
         conv_done_flag <= 1'b0;
      end else if (store) begin
         conv_done_flag <= 1'b1;
      end else if (rd_high || launch) begin
         conv_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         conv_done_irq_o <= 1'b0;
      end else begin
         conv_done_irq_o <= store;
      end
   end

   assign chan_sel_o        = channel_select[2:0];
   assign chan_valid_o      = ~channel_select[3];
   assign analog_input_en_o = ~analog_input_disable;
   assign ladder_connect_o  = ladder_always_on | conv.busy;
   assign sample_o          = conv.sample;
   assign dac_code_o        = conv.dac_code;

   // Helper counters that only the checks read
   logic [10:0] busy_cnt;
   logic [10:0] exp_cnt;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy_cnt <= 11'h000;
         exp_cnt  <= 11'h000;
      end else if (launch) begin
         busy_cnt <= 11'h000;
         exp_cnt  <= 11'(CONV_PHASES) * 11'(conv.period);
      end else if (conv.busy) begin
         busy_cnt <= busy_cnt + 11'h001;
      end
   end

   chk_start_launch: assert property (@(posedge clk_i) disable iff (srst_i)
      (wr_ctrl1 && avs_writedata_i[C1_START] && avs_writedata_i[6:5] == 2'b01
       && !conv.busy) ##1 !standby_i |=> conv_busy_flag)
      else $error("start write did not raise busy");
   chk_start_selfclr: assert property (@(posedge clk_i) disable iff (srst_i)
      conv_start_bit |=> !conv_start_bit)
      else $error("start bit not cleared");
   chk_mode_decode: assert property (@(posedge clk_i) disable iff (srst_i)
      launch |-> (operating_mode_field == MODE_SINGLE || operating_mode_field == MODE_REPEAT))
      else $error("launch in disabled or reserved mode");
   chk_chan_valid: assert property (@(posedge clk_i) disable iff (srst_i)
      chan_valid_o == (channel_select < 4'h8))
      else $error("channel valid wrong");
   chk_input_enable: assert property (@(posedge clk_i) disable iff (srst_i)
      standby_i |=> !analog_input_en_o)
      else $error("analog input left on in standby");
   chk_ladder_link: assert property (@(posedge clk_i) disable iff (srst_i)
      (!ladder_always_on && !conv_busy_flag) |-> !ladder_connect_o)
      else $error("ladder connected while idle");
   chk_conv_length: assert property (@(posedge clk_i) disable iff (srst_i)
      conv.done |-> busy_cnt == exp_cnt)
      else $error("conversion length wrong");
   chk_result_store: assert property (@(posedge clk_i) disable iff (srst_i)
      store |=> conv_done_flag && result == $past(conv.result) && conv_done_irq_o)
      else $error("result not stored on completion");
   chk_read_clear: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_high && !store) |=> !conv_done_flag)
      else $error("high result read kept done flag");
   chk_busy_standby: assert property (@(posedge clk_i) disable iff (srst_i)
      standby_i |=> !conv_busy_flag)
      else $error("busy survived standby");
   chk_repeat_again: assert property (@(posedge clk_i) disable iff (srst_i)
      (conv.done && operating_mode_field == MODE_REPEAT) ##1
      (!standby_i && operating_mode_field == MODE_REPEAT) |=> conv_busy_flag)
      else $error("repeat mode did not relaunch");
   chk_halt_nostore: assert property (@(posedge clk_i) disable iff (srst_i)
      (conv.busy && operating_mode_field == MODE_OFF) |=> !conv.busy ##1 $stable(result))
      else $error("halted conversion stored a result");
   chk_standby_ctrl: assert property (@(posedge clk_i) disable iff (srst_i)
      standby_i |=> ctrl1_val == CTRL1_RESET && ctrl2_val[5:0] == CTRL2_RESET[5:0])
      else $error("control not reset in standby");
   chk_keep_result: assert property (@(posedge clk_i) disable iff (srst_i)
      launch |=> !conv_done_flag && $stable(result))
      else $error("restart lost old result or kept done");
   chk_no_restart: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(standby_i) |-> !conv_busy_flag [*2])
      else $error("conversion restarted after standby");
endmodule

/* src/sadc_pkg.sv */
package sadc_pkg;
   localparam logic [11:0] IDX_RES_LOW  = 12'hfe0;
   localparam logic [11:0] IDX_RES_HIGH = 12'hfe1;
   localparam logic [11:0] IDX_CTRL1    = 12'hfe2;
   localparam logic [11:0] IDX_CTRL2    = 12'hfe3;
   localparam int          AW           = 14;
   localparam logic [AW-1:0] ADDR_RES_LOW  = {IDX_RES_LOW, 2'b00};
   localparam logic [AW-1:0] ADDR_RES_HIGH = {IDX_RES_HIGH, 2'b00};
   localparam logic [AW-1:0] ADDR_CTRL1    = {IDX_CTRL1, 2'b00};
   localparam logic [AW-1:0] ADDR_CTRL2    = {IDX_CTRL2, 2'b00};
   localparam logic [7:0]  CTRL1_RESET  = 8'h10;
   localparam logic [7:0]  CTRL2_RESET  = 8'h10;
   localparam logic [9:0]  RESULT_RESET = 10'h000;
   localparam int C1_START   = 7;
   localparam int C1_MODE_LO = 5;
   localparam int C1_AIN_DIS = 4;
   localparam int C2_LADDER  = 5;
   localparam int C2_TIME_LO = 1;
   localparam int R2_DONE    = 5;
   localparam int R2_BUSY    = 4;
   typedef enum logic [1:0] {
      MODE_OFF    = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_RSVD   = 2'b10,
      MODE_REPEAT = 2'b11
   } sadc_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_TRIAL  = 2'b11
   } sadc_state_t;
   // Conversion = 3 sample phases + 10 bit trials, all of one phase length
   localparam logic [3:0] CONV_PHASES   = 4'hd;
   localparam logic [3:0] SAMPLE_PHASES = 4'h3;
   localparam int CLK_MHZ      = 125;
   localparam int FC_MHZ       = 125;
   localparam int BASE_CONV_FC = 39;
   localparam int BASE_PERIOD  = BASE_CONV_FC * CLK_MHZ / FC_MHZ / 13;
   function automatic logic [6:0] sadc_period(input logic [2:0] code);
      case (code)
         3'b000:  sadc_period = 7'(BASE_PERIOD);
         3'b010:  sadc_period = 7'(BASE_PERIOD * 2);
         3'b011:  sadc_period = 7'(BASE_PERIOD * 4);
         3'b100:  sadc_period = 7'(BASE_PERIOD * 8);
         3'b101:  sadc_period = 7'(BASE_PERIOD * 16);
         default: sadc_period = 7'(BASE_PERIOD * 32);
      endcase
   endfunction
endpackage

/* src/sadc_conv_if.sv */
`timescale 1ns/10ps
interface sadc_conv_if;
   logic       start;
   logic       abort;
   logic [6:0] period;
   logic       busy;
   logic       done;
   logic       sample;
   logic [9:0] result;
   logic [9:0] dac_code;
   modport ctl (output start, abort, period, input busy, done, sample, result, dac_code);
   modport sar (input start, abort, period, output busy, done, sample, result, dac_code);
endinterface

/* src/sadc_sar.sv */
`timescale 1ns/10ps
module sadc_sar
   import sadc_pkg::*;
(
   input  wire logic clk_i,  // Clock
   input  wire logic srst_i, // Sync reset, high
   input  wire logic comp_i, // Comparator, asynchronous
   sadc_conv_if.sar  conv    // Sequencer control
);
   sadc_state_t state;
   logic       comp_meta;
   logic       comp_sync;
   logic [6:0] tick;
   logic [6:0] per_q;
   logic [3:0] phase;
   logic [9:0] mask;
   logic [9:0] sar_bits;
   logic       per_end;
   logic [9:0] decided;

   always_ff @(posedge clk_i) begin
      comp_meta <= comp_i;
      comp_sync <= comp_meta;
   end

   assign per_end = (tick == per_q - 7'h01);
   assign decided = comp_sync ? sar_bits : (sar_bits & ~mask);
   assign conv.busy     = (state != ST_IDLE);
   assign conv.sample   = (state == ST_SAMPLE);
   assign conv.dac_code = sar_bits;

   // Phase length is latched so a timing write cannot stretch a running conversion
   always_ff @(posedge clk_i) begin
      if (srst_i || conv.abort) begin
         state <= ST_IDLE;
         tick  <= 7'h00;
         phase <= 4'h0;
         mask  <= 10'h000;
         per_q <= 7'h01;
      end else begin
         case (state)
            ST_IDLE: begin
               if (conv.start) begin
                  state <= ST_SAMPLE;
                  tick  <= 7'h00;
                  phase <= 4'h0;
                  per_q <= conv.period;
               end
            end
            ST_SAMPLE: begin
               tick <= per_end ? 7'h00 : tick + 7'h01;
               if (per_end) begin
                  phase <= phase + 4'h1;
                  if (phase == SAMPLE_PHASES - 4'h1) begin
                     state <= ST_TRIAL;
                     mask  <= 10'h200;
                  end
               end
            end
            ST_TRIAL: begin
               tick <= per_end ? 7'h00 : tick + 7'h01;
               if (per_end) begin
                  phase <= phase + 4'h1;
                  mask  <= mask >> 1;
                  if (phase == CONV_PHASES - 4'h1) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || conv.abort) begin
         sar_bits <= 10'h000;
      end else if (state == ST_IDLE && conv.start) begin
         sar_bits <= 10'h000;
      end else if (state == ST_SAMPLE && per_end && phase == SAMPLE_PHASES - 4'h1) begin
         sar_bits <= 10'h200;
      end else if (state == ST_TRIAL && per_end) begin
         sar_bits <= decided | (mask >> 1);
      end
   end

   // Abort clears done and the result here, so partial codes are never published
   always_ff @(posedge clk_i) begin
      if (srst_i || conv.abort) begin
         conv.done   <= 1'b0;
         conv.result <= RESULT_RESET;
      end else begin
         conv.done <= (state == ST_TRIAL) && per_end && (phase == CONV_PHASES - 4'h1);
         if ((state == ST_TRIAL) && per_end && (phase == CONV_PHASES - 4'h1)) begin
            conv.result <= decided;
         end
      end
   end
endmodule

/* tb/sadc_analog_model.sv */
`timescale 1ns/10ps
module sadc_analog_model (
   input  wire logic       clk_i,        // Clock
   input  wire logic [9:0] level_i [8],  // Pin voltages as ideal codes
   input  wire logic [2:0] chan_sel_i,   // Mux channel
   input  wire logic       chan_valid_i, // Channel code usable
   input  wire logic       input_en_i,   // Analog path on
   input  wire logic       ladder_i,     // Ladder connected
   input  wire logic [9:0] dac_code_i,   // Trial code
   output logic            comp_o        // Comparator decision
);
   logic toggle = 1'b0;
   always @(posedge clk_i) begin
      toggle <= ~toggle;
   end
   // A dead path or open ladder gives garbage, never a held level
   assign comp_o = (chan_valid_i && input_en_i && ladder_i) ?
                   (level_i[chan_sel_i] >= dac_code_i) : toggle;
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench
   import sadc_pkg::*;
;
   logic          clk_i = 1'b0;
   logic          srst_i = 1'b1;
   logic          standby_i = 1'b0;
   logic          rd = 1'b0;
   logic          wr = 1'b0;
   logic [AW-1:0] addr = '0;
   logic [3:0]    be = 4'hf;
   logic [31:0]   wdata = 32'h0;
   logic [31:0]   rdata;
   logic          waitreq, comp, c_val, a_en, lad, smp, irq;
   logic [2:0]    c_sel;
   logic [9:0]    dac;
   logic [9:0]    level [8];
   logic [2:0]    codes [6] = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110};
   logic          s_lad, s_en, s_val;
   logic [2:0]    s_sel;
   int            err_total = 0;
   int            samples_checked = 0;
   int            irq_cnt = 0;
   int            run_len = 0;
   int            last_len = 0;

   always #4 clk_i = ~clk_i;

   sadc_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .standby_i(standby_i),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
      .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .comp_i(comp), .chan_sel_o(c_sel), .chan_valid_o(c_val), .analog_input_en_o(a_en),
      .ladder_connect_o(lad), .sample_o(smp), .dac_code_o(dac), .conv_done_irq_o(irq));

   sadc_analog_model i_model (.clk_i(clk_i), .level_i(level), .chan_sel_i(c_sel),
      .chan_valid_i(c_val), .input_en_i(a_en), .ladder_i(lad), .dac_code_i(dac),
      .comp_o(comp));

   // Mid-cycle snapshots keep checks clear of edge races
   always @(negedge clk_i) begin
      s_lad = lad;
      s_en = a_en;
      s_val = c_val;
      s_sel = c_sel;
      if (irq === 1'b1) irq_cnt++;
      if (lad === 1'b1) run_len++;
      else if (run_len != 0) begin
         last_len = run_len;
         run_len = 0;
      end
   end

   function automatic int per(input logic [2:0] tc);
      case (tc)
         3'b000:  return 3;
         3'b010:  return 6;
         3'b011:  return 12;
         3'b100:  return 24;
         3'b101:  return 48;
         default: return 96;
      endcase
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Entered at a rising edge; leaves one idle cycle so strobes never toggle twice
   task automatic bus(input logic we, input logic [AW-1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int   n;
      logic ok;
      n = 0;
      ok = 1'b0;
      q = 8'h00;
      rd <= !we;
      wr <= we;
      addr <= a;
      wdata <= {24'h0, d};
      // Waitrequest and read data are taken at the same rising edge
      while (!ok && n < 50) begin
         @(posedge clk_i);
         ok = !waitreq;
         q = rdata[7:0];
         n++;
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
      if (!ok) begin
         err_total++;
         conclude();
      end
   endtask

   task automatic wait_done(output logic [7:0] q);
      int n;
      n = 0;
      q = 8'h00;
      while (q[5] !== 1'b1 && n < 600) begin
         bus(1'b0, ADDR_RES_LOW, 8'h00, q);
         n++;
      end
      if (q[5] !== 1'b1) begin
         err_total++;
         conclude();
      end
   endtask

   task automatic conv1(input logic [2:0] ch, input logic [2:0] tc, input logic rd_hi);
      logic [7:0] q;
      int         i0;
      i0 = irq_cnt;
      last_len = 0;
      bus(1'b1, ADDR_CTRL2, {4'h1, tc, 1'b0}, q);
      bus(1'b0, ADDR_CTRL2, 8'h00, q);
      chk(q & 8'h3f, {4'h1, tc, 1'b0});
      bus(1'b1, ADDR_CTRL1, {4'b1010, 1'b0, ch}, q);
      chk(s_en, 1'b1);
      chk(s_sel, ch);
      bus(1'b0, ADDR_RES_LOW, 8'h00, q);
      chk(q[4], 1'b1);
      bus(1'b0, ADDR_CTRL1, 8'h00, q);
      chk(q, {4'b0010, 1'b0, ch});
      wait_done(q);
      chk(q[7:4], {level[ch][1:0], 2'b10});
      chk(16'(last_len), 16'(13 * per(tc)));
      chk(16'(irq_cnt - i0), 16'd1);
      if (rd_hi) begin
         bus(1'b0, ADDR_RES_HIGH, 8'h00, q);
         chk(q, level[ch][9:2]);
         bus(1'b0, ADDR_RES_LOW, 8'h00, q);
         chk(q[5], 1'b0);
      end
   endtask

   initial begin
      logic [7:0] q;
      logic [2:0] ch;
      logic [9:0] old;
      int         i0;
      void'($urandom(32'haa14));
      foreach (level[i]) level[i] = 10'($urandom);
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, ADDR_CTRL1, 8'h00, q);
      chk(q, 8'h10);
      bus(1'b0, ADDR_CTRL2, 8'h00, q);
      chk(q & 8'h2e, 8'h00);
      bus(1'b0, ADDR_RES_HIGH, 8'h00, q);
      chk(q, 8'h00);
      bus(1'b0, ADDR_CTRL2 + 14'h4, 8'h00, q);
      chk(q, 8'h00);
      chk(s_en, 1'b0);
      // Extreme input codes first, then every legal time code
      level[0] <= 10'h000;
      level[7] <= 10'h3ff;
      conv1(3'd0, 3'b000, 1'b1);
      conv1(3'd7, 3'b010, 1'b1);
      foreach (codes[i]) begin
         ch = 3'($urandom_range(0, 7));
         level[ch] <= 10'($urandom);
         conv1(ch, codes[i], 1'b1);
      end
      // Restart before the high byte is read
      conv1(3'd3, 3'b011, 1'b0);
      old = level[3];
      level[3] <= ~old;
      bus(1'b1, ADDR_CTRL1, 8'ha3, q);
      bus(1'b0, ADDR_RES_LOW, 8'h00, q);
      chk(q[7:5], {old[1:0], 1'b0});
      bus(1'b0, ADDR_RES_HIGH, 8'h00, q);
      chk(q, old[9:2]);
      wait_done(q);
      bus(1'b0, ADDR_RES_HIGH, 8'h00, q);
      chk(q, level[3][9:2]);
      // Repeat mode, then stop it
      i0 = irq_cnt + 3;
      bus(1'b1, ADDR_CTRL2, 8'h10, q);
      bus(1'b1, ADDR_CTRL1, 8'he5, q);
      for (int n = 0; n < 200 && irq_cnt < i0; n++) @(posedge clk_i);
      chk(16'(irq_cnt >= i0), 16'd1);
      chk(16'(last_len), 16'd39);
      bus(1'b1, ADDR_CTRL1, 8'h05, q);
      // Busy drops one edge after the mode write lands
      repeat (2) @(posedge clk_i);
      chk(s_lad, 1'b0);
      i0 = irq_cnt;
      repeat (100) @(posedge clk_i);
      chk(16'(irq_cnt - i0), 16'd0);
      // Start with disabled and reserved modes
      for (int m = 0; m < 4; m += 2) begin
         i0 = irq_cnt;
         bus(1'b1, ADDR_CTRL1, {1'b1, 2'(m), 5'h02}, q);
         repeat (60) @(posedge clk_i);
         chk(s_lad, 1'b0);
         chk(16'(irq_cnt - i0), 16'd0);
      end
      bus(1'b1, ADDR_CTRL2, 8'h30, q);
      chk(s_lad, 1'b1);
      bus(1'b1, ADDR_CTRL2, 8'h10, q);
      chk(s_lad, 1'b0);
      bus(1'b1, ADDR_CTRL1, 8'h1c, q);
      chk(s_val, 1'b0);
      chk(s_en, 1'b0);
      // Standby in mid-conversion
      bus(1'b1, ADDR_CTRL2, 8'h1c, q);
      bus(1'b1, ADDR_CTRL1, 8'ha6, q);
      repeat (100) @(posedge clk_i);
      i0 = irq_cnt;
      standby_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(s_lad, 1'b0);
      bus(1'b1, ADDR_CTRL1, 8'h2f, q);
      bus(1'b0, ADDR_CTRL1, 8'h00, q);
      chk(q, 8'h10);
      bus(1'b0, ADDR_RES_LOW, 8'h00, q);
      chk(q[5:4], 2'b00);
      standby_i <= 1'b0;
      repeat (50) @(posedge clk_i);
      chk(s_lad, 1'b0);
      chk(16'(irq_cnt - i0), 16'd0);
      bus(1'b0, ADDR_CTRL2, 8'h00, q);
      chk(q & 8'h2e, 8'h00);
      conclude();
   end
endmodule
